// *** logic/nvh_host.sv ***
// Host controller driving the nonvolatile static memory pins
// Operation
// - Host holds address stable through write
// - Data valid before write strobe rises
// - Host keeps output gate high writing
// - Pin pulled low requests a store
// - Write strobe inactive high from reset
// - Six-read sequence starts software store
`timescale 1ns/100ps
module nvh_host
    import nvh_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // User request
    input  wire nvh_req_t          req,
    input  wire logic              req_valid,
    output logic                   req_ready,
    output logic [DATA_W-1:0]      rdata,
    output logic                   rdata_valid,
    // Store requests
    input  wire logic              hw_store_req,
    input  wire logic              sw_store_req,
    output logic                   store_active,
    output logic                   writes_pending,
    // Memory pins
    output nvh_pins_t              pins,
    input  wire logic [DATA_W-1:0] data_lines_i,
    output logic [DATA_W-1:0]      data_lines_o,
    output logic                   data_lines_oe,
    input  wire logic              store_busy_n_i,
    output logic                   store_busy_n_o,
    output logic                   store_busy_n_oe
);

    nvh_state_t        state_q;
    nvh_req_t          cur_q;
    logic [3:0]        cnt_q;
    logic [2:0]        seq_q;
    logic              sw_seq_q;
    logic              dirty_q;
    logic              busy_seen_q;

    // Address of a given step of the store sequence
    function automatic logic [15:0] seq_addr(input logic [2:0] i);
        logic [15:0] a;
        a = SEQ_A5;
        unique case (i)
            3'd0: a = SEQ_A0;
            3'd1: a = SEQ_A1;
            3'd2: a = SEQ_A2;
            3'd3: a = SEQ_A3;
            3'd4: a = SEQ_A4;
            default: a = SEQ_A5;
        endcase
        return a;
    endfunction

    wire logic busy_low = !store_busy_n_i;

    assign req_ready      = (state_q == ST_IDLE) && !busy_low
                            && !sw_seq_q && !hw_store_req;
    assign store_active   = (state_q == ST_HWREQ) || (state_q == ST_BUSY);
    assign writes_pending = dirty_q;

    assign store_busy_n_o  = 1'b0;
    // Pull only with writes pending, so a clean hardware store never blips busy
    assign store_busy_n_oe = (state_q == ST_HWREQ) && dirty_q;

    // ---------------------------------------------------------------
    // Access sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q  <= ST_IDLE;
            cur_q    <= '0;
            cnt_q    <= 4'h0;
            seq_q    <= 3'd0;
            sw_seq_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= SETUP_CNT;
                    if (busy_low)
                        state_q <= ST_BUSY;
                    else if (sw_seq_q || sw_store_req)
                    begin
                        sw_seq_q     <= 1'b1;
                        cur_q.write  <= 1'b0;
                        cur_q.addr   <= {1'b0, seq_addr(seq_q)};
                        cur_q.wdata  <= '0;
                        state_q      <= ST_SETUP;
                    end
                    else if (hw_store_req)
                        state_q <= ST_HWREQ;
                    else if (req_valid)
                    begin
                        cur_q   <= req;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (cnt_q <= 4'h1)
                    begin
                        cnt_q   <= STROBE_CNT;
                        state_q <= ST_STROBE;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                ST_STROBE:
                begin
                    if (cnt_q <= 4'h1)
                        state_q <= ST_END;
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                ST_END:
                begin
                    state_q <= ST_IDLE;
                    if (sw_seq_q)
                    begin
                        if (seq_q == 3'(SEQ_LEN - 1))
                        begin
                            seq_q    <= 3'd0;
                            sw_seq_q <= 1'b0;
                            state_q  <= ST_BUSY;
                        end
                        else
                            seq_q <= seq_q + 3'd1;
                    end
                end
                ST_HWREQ:
                begin
                    if (busy_low || !dirty_q)
                        state_q <= ST_BUSY;
                end
                ST_BUSY:
                begin
                    if (!busy_low)
                        state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pins          <= '{chip_sel_n: 1'b1, write_n: 1'b1,
                               out_gate_n: 1'b1, addr_lines: '0};
            data_lines_o  <= '0;
            data_lines_oe <= 1'b0;
        end
        else
        begin
            pins.addr_lines <= cur_q.addr;
            data_lines_o    <= cur_q.wdata;
            // Strobes; gate stays high on write
            pins.chip_sel_n <= !(state_q == ST_SETUP
                                 || state_q == ST_STROBE);
            pins.write_n    <= !(state_q == ST_STROBE && cur_q.write);
            pins.out_gate_n <= !(state_q == ST_STROBE && !cur_q.write);
            // Data driven across the rising write strobe
            data_lines_oe   <= cur_q.write
                               && (state_q == ST_SETUP
                                   || state_q == ST_STROBE
                                   || state_q == ST_END);
        end
    end

    // ---------------------------------------------------------------
    // Read capture and write tracking
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata       <= '0;
            rdata_valid <= 1'b0;
        end
        else
        begin
            rdata_valid <= 1'b0;
            if (state_q == ST_END && !cur_q.write && !sw_seq_q)
            begin
                rdata       <= data_lines_i;
                rdata_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            dirty_q     <= 1'b1;
            busy_seen_q <= 1'b0;
        end
        else
        begin
            busy_seen_q <= busy_low;
            // Write sets; store end (busy released) clears; set wins
            if (state_q == ST_END && cur_q.write)
                dirty_q <= 1'b1;
            else if (busy_seen_q && !busy_low)
                dirty_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_gate_write_excl: assert property (@(posedge sys_clk)
        disable iff (reset)
        !(!pins.write_n && !pins.out_gate_n))
        else $error("Gate and write strobe low together");
    a_addr_stable_wr: assert property (@(posedge sys_clk)
        disable iff (reset)
        (!pins.write_n && $past(!pins.write_n))
            |-> $stable(pins.addr_lines))
        else $error("Address moved during write");
    a_data_before_rise: assert property (@(posedge sys_clk)
        disable iff (reset)
        $rose(pins.write_n) |-> data_lines_oe)
        else $error("Write data not driven at strobe rise");
    a_idle_strobes: assert property (@(posedge sys_clk)
        disable iff (reset)
        $past(state_q == ST_BUSY) && $past(state_q, 2) == ST_BUSY
            |-> pins.chip_sel_n && pins.write_n)
        else $error("Strobe active while store busy");
    a_hw_store_pull: assert property (@(posedge sys_clk)
        disable iff (reset)
        store_busy_n_oe |-> dirty_q)
        else $error("Busy pin pulled without pending writes");
    a_seq_busy: assert property (@(posedge sys_clk)
        disable iff (reset)
        (state_q == ST_END && sw_seq_q && seq_q == 3'd5)
            |=> state_q == ST_BUSY)
        else $error("Sequence end did not wait for store");
    a_ready_block: assert property (@(posedge sys_clk)
        disable iff (reset)
        busy_low |-> !req_ready)
        else $error("Request accepted during store");
    a_write_pulse: assert property (@(posedge sys_clk)
        disable iff (reset)
        $fell(pins.write_n) |-> !pins.write_n [*2])
        else $error("Write strobe shorter than least time");

    c_read: cover property (@(posedge sys_clk) rdata_valid);
    c_write: cover property (@(posedge sys_clk) $rose(pins.write_n));
    c_sw_store: cover property (@(posedge sys_clk)
        state_q == ST_END && seq_q == 3'd5);
    c_hw_store: cover property (@(posedge sys_clk) store_busy_n_oe);

endmodule

// *** logic/nvh_pkg.sv ***
// Package for the host-side controller of the nonvolatile static memory
package nvh_pkg;

    localparam int unsigned ADDR_W        = 17;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned SEQ_LEN       = 6;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Least strobe-low time and least address setup, in ns
    localparam int unsigned T_STROBE_NS   = 200;
    localparam int unsigned T_SETUP_NS    = 100;
    // Cycle counts: least times round up, never below one cycle
    localparam int unsigned STROBE_CYC    =
        (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYC     =
        (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  STROBE_CNT    = 4'(STROBE_CYC);
    localparam logic [3:0]  SETUP_CNT     = 4'(SETUP_CYC);

    // Store-arming address sequence; the last word triggers the store
    localparam logic [15:0] SEQ_A0 = 16'h4E38;
    localparam logic [15:0] SEQ_A1 = 16'hB1C7;
    localparam logic [15:0] SEQ_A2 = 16'h83E0;
    localparam logic [15:0] SEQ_A3 = 16'h7C1F;
    localparam logic [15:0] SEQ_A4 = 16'h703F;
    localparam logic [15:0] SEQ_A5 = 16'h8FC0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b010,
        ST_END    = 3'b011,
        ST_HWREQ  = 3'b100,
        ST_BUSY   = 3'b101
    } nvh_state_t;

    // User-side request carrier
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvh_req_t;

    // Memory pins driven by the host
    typedef struct packed {
        logic              chip_sel_n;
        logic              write_n;
        logic              out_gate_n;
        logic [ADDR_W-1:0] addr_lines;
    } nvh_pins_t;

endpackage

// *** verification/nvh_host_tb.sv ***
// Self-checking testbench for the nonvolatile memory host
`timescale 1ns/100ps
module nvh_host_tb
    import nvh_pkg::*;
;
    logic              sys_clk, reset, req_valid, req_ready;
    logic              rdata_valid, hw_store_req, sw_store_req;
    logic              store_active, writes_pending, h_oe, dev_oe;
    logic              b_o, b_oe, dev_b_oe, busy_n;
    logic [DATA_W-1:0] rdata, bus, h_d, dev_d, last_q;
    nvh_req_t          req;
    nvh_pins_t         pins;
    int                store_count;
    int                errors = 0;
    int                samples_checked = 0;

    // Pull-up on busy; a released data bus shows the inverse value
    assign busy_n = ((b_oe && !b_o) || dev_b_oe) ? 1'b0 : 1'b1;
    assign bus = h_oe ? h_d : (dev_oe ? dev_d : ~last_q);
    always @(bus)
        if (h_oe || dev_oe)
            last_q = bus;

    nvh_host i_dut (.sys_clk(sys_clk), .reset(reset), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
        .rdata_valid(rdata_valid), .hw_store_req(hw_store_req),
        .sw_store_req(sw_store_req), .store_active(store_active),
        .writes_pending(writes_pending), .pins(pins),
        .data_lines_i(bus), .data_lines_o(h_d), .data_lines_oe(h_oe),
        .store_busy_n_i(busy_n), .store_busy_n_o(b_o),
        .store_busy_n_oe(b_oe));
    nvh_mem_model i_mem (.pins(pins), .data_bus(bus), .busy_n(busy_n),
        .dev_d(dev_d), .dev_oe(dev_oe), .busy_oe(dev_b_oe),
        .store_count(store_count));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ------------------------------------------
    // Compare, wait and access tasks
    // ------------------------------------------
    task automatic final_report();
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_bit(string n, logic e, logic s);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %b seen %b", n, e, s);
        end
    endtask

    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] s);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // Bounded wait, sampled just after each edge
    task automatic wait_for(string n, ref logic s, input logic v);
        int k;
        k = 0;
        #1;
        while (s !== v)
        begin
            @(posedge sys_clk);
            #1;
            k++;
            if (k > 400)
            begin
                errors++;
                $display("Error %s expected %b seen %b", n, v, s);
                final_report();
            end
        end
    endtask

    task automatic access(logic w, logic [16:0] a, logic [7:0] d);
        wait_for("req_ready", req_ready, 1'b1);
        @(posedge sys_clk);
        req <= '{write: w, addr: a, wdata: d};
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        if (w)
            wait_for("req_ready", req_ready, 1'b1);
        else
            wait_for("rdata_valid", rdata_valid, 1'b1);
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic t_reset();
        chk_bit("write_n", 1'b1, pins.write_n);
        chk_bit("chip_sel_n", 1'b1, pins.chip_sel_n);
        chk_bit("busy_n", 1'b1, busy_n);
        chk_bit("pending", 1'b1, writes_pending);
    endtask

    task automatic t_wr_rd();
        access(1'b1, 17'h1_2345, 8'hA5);
        access(1'b1, 17'h0_2345, 8'h5A);
        access(1'b0, 17'h1_2345, 8'h00);
        chk_byte("rdata", 8'hA5, rdata);
        access(1'b0, 17'h0_2345, 8'h00);
        chk_byte("rdata", 8'h5A, rdata);
    endtask

    task automatic t_hw_store();
        @(posedge sys_clk);
        hw_store_req <= 1'b1;
        wait_for("busy_n", busy_n, 1'b0);
        chk_bit("store_active", 1'b1, store_active);
        chk_bit("req_ready", 1'b0, req_ready);
        @(posedge sys_clk);
        hw_store_req <= 1'b0;
        wait_for("busy_n", busy_n, 1'b1);
        repeat (3) @(posedge sys_clk);
        chk_byte("stores", 8'h01, 8'(store_count));
        chk_bit("pending", 1'b0, writes_pending);
    endtask

    task automatic t_hw_clean();
        @(posedge sys_clk);
        hw_store_req <= 1'b1;
        repeat (20)
        begin
            @(posedge sys_clk);
            #1;
            chk_bit("busy_n", 1'b1, busy_n);
        end
        @(posedge sys_clk);
        hw_store_req <= 1'b0;
        chk_byte("stores", 8'h01, 8'(store_count));
    endtask

    task automatic t_sw_store();
        @(posedge sys_clk);
        sw_store_req <= 1'b1;
        @(posedge sys_clk);
        sw_store_req <= 1'b0;
        wait_for("busy_n", busy_n, 1'b0);
        chk_bit("req_ready", 1'b0, req_ready);
        wait_for("busy_n", busy_n, 1'b1);
        chk_byte("stores", 8'h02, 8'(store_count));
        access(1'b0, 17'h1_2345, 8'h00);
        chk_byte("rdata", 8'hA5, rdata);
        access(1'b1, 17'h1_FFFF, 8'h3C);
        repeat (2) @(posedge sys_clk);
        chk_bit("pending", 1'b1, writes_pending);
    endtask

    initial
    begin
        reset = 1'b1;
        req = '0;
        req_valid = 1'b0;
        hw_store_req = 1'b0;
        sw_store_req = 1'b0;
        last_q = 8'h00;
        repeat (16) @(posedge sys_clk);
        t_reset();
        reset <= 1'b0;
        t_wr_rd();
        t_hw_store();
        t_hw_clean();
        t_sw_store();
        final_report();
    end
endmodule

// *** verification/nvh_mem_model.sv ***
// Behavioural model of the nonvolatile static memory
`timescale 1ns/100ps
module nvh_mem_model
    import nvh_pkg::*;
#(
    parameter int STORE_NS = 3000
)
(
    // Pins from the host
    input  wire nvh_pins_t         pins,
    input  wire logic [DATA_W-1:0] data_bus,
    input  wire logic              busy_n,
    // Device drive and store count
    output logic [DATA_W-1:0]      dev_d,
    output logic                   dev_oe,
    output logic                   busy_oe,
    output int                     store_count
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [15:0]       seq [SEQ_LEN] =
        '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
    nvh_pins_t         p_d;
    logic [DATA_W-1:0] d_d;
    logic              storing = 1'b0;
    logic              dirty   = 1'b0;
    int                idx     = 0;
    logic              wr_armed = 1'b1;
    wire logic         in_wr   = !pins.chip_sel_n && !pins.write_n
                                 && busy_n && !storing;

    // Delayed copies give the strobes a hold time
    assign #1 p_d = pins;
    assign #1 d_d = data_bus;
    assign dev_oe = !pins.chip_sel_n && !pins.out_gate_n
                    && pins.write_n && busy_n && !storing;
    assign dev_d = mem[pins.addr_lines];
    assign busy_oe = storing;
    initial store_count = 0;

    task automatic run_store();
        storing = 1'b1;
        #(STORE_NS);
        storing = 1'b0;
        // strobes already low after a store stay inhibited
        wr_armed = pins.chip_sel_n || pins.write_n;
        dirty = 1'b0;
        idx = 0;
        store_count++;
    endtask

    always @(negedge in_wr)
        if (wr_armed)
        begin
            mem[p_d.addr_lines] = d_d;
            dirty = 1'b1;
            idx = 0;
        end
    // a new falling strobe re-arms writes
    always @(negedge pins.chip_sel_n or negedge pins.write_n)
        wr_armed = 1'b1;
    always @(posedge pins.chip_sel_n)
        if (p_d.write_n === 1'b1 && !storing)
        begin
            if (p_d.addr_lines[15:0] === seq[idx])
                idx++;
            else
                idx = 0;
            if (idx == SEQ_LEN)
                run_store();
        end
    always @(negedge busy_n)
        if (!storing && dirty)
            run_store();
endmodule
